// *** hw/tovf_regs.svh ***
// Timer control flag register: address, bit positions, reset value
`ifndef TOVF_REGS_SVH
`define TOVF_REGS_SVH

`define TOVF_CTRL_ADDR 8'h88
`define TOVF_CTRL_RESET 8'h00
`define TOVF_RESET_T1_FLAG 1'b0
`define TOVF_RESET_T1_RUN 1'b0
`define TOVF_RESET_T0_FLAG 1'b0
`define TOVF_RESET_T0_RUN 1'b0
`define TOVF_BIT_T1_FLAG 3'd7
`define TOVF_BIT_T1_RUN 3'd6
`define TOVF_BIT_T0_FLAG 3'd5
`define TOVF_BIT_T0_RUN 3'd4
`define TOVF_LOW_NIBBLE_READ 4'h0

`endif

// *** hw/tovf_pkg.sv ***
// Types shared by the timer overflow flag block
package tovf_pkg;
    typedef logic [7:0] tovf_byte_t;
    typedef logic [2:0] tovf_bitsel_t;
endpackage

// *** hw/tovf_rst_sync.sv ***
// Reset release synchroniser: asserts at once, releases after two clocks
module tovf_rst_sync (
    // Clock and raw reset
    input wire logic clock,
    input wire logic rst_n,
    // Synchronised reset
    output logic rst_sync_n
);
    logic [1:0] stage_q;
    logic [1:0] stage_d;

    always_comb begin
        stage_d = {stage_q[0], 1'b1};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= 2'b00;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign rst_sync_n = stage_q[1];
endmodule

// *** hw/tovf_timer_flags.sv ***
// Timer control register: overflow flags and run controls of timers zero and one
//
// Notes on behaviour
// - Timer one overflow sets the timer one flag, bit 7.
// - Vectoring to the timer one service routine clears the timer one flag.
// - Timer zero overflow sets the timer zero flag, bit 5.
// - Vectoring to the timer zero service routine clears the timer zero flag.
// - Software writes may clear either flag, besides the vectoring clear.
// - Timer zero runs only while its run bit, bit 4, is 1.
// - In split mode the upper byte overflow sets the timer one flag.
`include "tovf_regs.svh"

module tovf_timer_flags #(
    parameter logic [7:0] SFR_ADDR = `TOVF_CTRL_ADDR
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Special function register bus, byte access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Special function register bus, single bit write
    input wire logic [7:0] bit_addr,
    input wire logic bit_wr,
    input wire logic bit_wdata,
    // Overflow pulses from the counters
    input wire logic timer_zero_ovf,
    input wire logic timer_one_ovf,
    input wire logic timer_zero_upper_byte_ovf,
    input wire logic timer_zero_split_mode,
    // Interrupt vectoring acknowledges
    input wire logic vector_timer_zero,
    input wire logic vector_timer_one,
    // Run enables and interrupt requests
    output logic timer_zero_run,
    output logic timer_one_run,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    // Bit addressing needs the register on an eight-aligned address
    if (SFR_ADDR[2:0] != 3'h0) begin : g_addr_check
        $error("SFR_ADDR must be a multiple of eight");
    end

    // Stored bits sit in the upper nibble; the lower nibble always reads zero
    if (`TOVF_BIT_T0_RUN < 3'd4) begin : g_bit_check
        $error("Register bits must lie in the upper nibble");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset

    logic rst_sync_n;

    tovf_rst_sync u_rst_sync (
        .clock(clock),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Hardware set wins over every clear; a write beats the vectoring clear
    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic vec_clr,
        input logic wr_en,
        input logic wr_val
    );
        logic res;
        res = cur;
        if (set) begin
            res = 1'b1;
        end else if (wr_en) begin
            res = wr_val;
        end else if (vec_clr) begin
            res = 1'b0;
        end
        return res;
    endfunction

    function automatic logic bit_of(input tovf_pkg::tovf_byte_t val, input tovf_pkg::tovf_bitsel_t sel);
        return val[sel];
    endfunction

    // Byte strobes compare the whole address, bit strobes only the upper five bits
    function automatic logic byte_match(input tovf_pkg::tovf_byte_t addr);
        return addr == SFR_ADDR;
    endfunction

    function automatic logic bit_match(input tovf_pkg::tovf_byte_t addr);
        return addr[7:3] == SFR_ADDR[7:3];
    endfunction

    function automatic tovf_pkg::tovf_byte_t pack_reg(
        input logic flag1,
        input logic run1,
        input logic flag0,
        input logic run0
    );
        tovf_pkg::tovf_byte_t res;
        res = {4'h0, `TOVF_LOW_NIBBLE_READ};
        res[`TOVF_BIT_T1_FLAG] = flag1;
        res[`TOVF_BIT_T1_RUN] = run1;
        res[`TOVF_BIT_T0_FLAG] = flag0;
        res[`TOVF_BIT_T0_RUN] = run0;
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic byte_hit;
    logic bit_hit;
    logic read_hit;
    tovf_pkg::tovf_byte_t wr_mask;
    tovf_pkg::tovf_byte_t wr_val;

    always_comb begin
        byte_hit = sfr_wr && byte_match(sfr_addr);
        bit_hit = bit_wr && bit_match(bit_addr);
        read_hit = sfr_rd && byte_match(sfr_addr);
        wr_mask = 8'h00;
        wr_val = 8'h00;
        if (byte_hit) begin
            wr_mask = 8'hFF;
            wr_val = sfr_wdata;
        end else if (bit_hit) begin
            wr_mask = 8'h01 << bit_addr[2:0];
            wr_val = {8{bit_wdata}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow events

    logic t0_event;
    logic t1_event;

    always_comb begin
        // A halted counter produces no overflow
        t0_event = timer_zero_ovf && timer_zero_run;
        if (timer_zero_split_mode) begin
            // Split mode: timer one cannot touch its flag, the upper byte owns it
            t1_event = timer_zero_upper_byte_ovf && timer_one_run;
        end else begin
            t1_event = timer_one_ovf && timer_one_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flags

    logic t1_flag_q;
    logic t1_flag_d;
    logic t0_flag_q;
    logic t0_flag_d;

    always_comb begin
        t1_flag_d = flag_next(t1_flag_q, t1_event, vector_timer_one,
            bit_of(wr_mask, `TOVF_BIT_T1_FLAG), bit_of(wr_val, `TOVF_BIT_T1_FLAG));
        t0_flag_d = flag_next(t0_flag_q, t0_event, vector_timer_zero,
            bit_of(wr_mask, `TOVF_BIT_T0_FLAG), bit_of(wr_val, `TOVF_BIT_T0_FLAG));
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            t1_flag_q <= `TOVF_RESET_T1_FLAG;
            t0_flag_q <= `TOVF_RESET_T0_FLAG;
        end else begin
            t1_flag_q <= t1_flag_d;
            t0_flag_q <= t0_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run controls

    logic t1_run_q;
    logic t1_run_d;
    logic t0_run_q;
    logic t0_run_d;

    always_comb begin
        t1_run_d = t1_run_q;
        if (bit_of(wr_mask, `TOVF_BIT_T1_RUN)) begin
            t1_run_d = bit_of(wr_val, `TOVF_BIT_T1_RUN);
        end
        t0_run_d = t0_run_q;
        if (bit_of(wr_mask, `TOVF_BIT_T0_RUN)) begin
            t0_run_d = bit_of(wr_val, `TOVF_BIT_T0_RUN);
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            t1_run_q <= `TOVF_RESET_T1_RUN;
            t0_run_q <= `TOVF_RESET_T0_RUN;
        end else begin
            t1_run_q <= t1_run_d;
            t0_run_q <= t0_run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    tovf_pkg::tovf_byte_t rdata_q;
    tovf_pkg::tovf_byte_t rdata_d;

    always_comb begin
        // State before any same-cycle write, one cycle after the strobe; idle reads zero
        rdata_d = 8'h00;
        if (read_hit) begin
            rdata_d = pack_reg(t1_flag_q, t1_run_q, t0_flag_q, t0_run_q);
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= `TOVF_CTRL_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign timer_zero_run = t0_run_q;
    assign timer_one_run = t1_run_q;
    assign timer_zero_overflow_flag = t0_flag_q;
    assign timer_one_overflow_flag = t1_flag_q;
    assign sfr_rdata = rdata_q;
endmodule

// *** dv/tovf_timer_flags_assertions.sv ***
// Checker on the timer overflow flag ports
module tovf_timer_flags_assertions (
    // Clock, reset, strobes
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sfr_wr,
    input wire logic bit_wr,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    // Events
    input wire logic timer_zero_ovf,
    input wire logic timer_one_ovf,
    input wire logic timer_zero_upper_byte_ovf,
    input wire logic timer_zero_split_mode,
    input wire logic vector_timer_zero,
    input wire logic vector_timer_one,
    // Outputs
    input wire logic timer_zero_run,
    input wire logic timer_one_run,
    input wire logic timer_zero_overflow_flag,
    input wire logic timer_one_overflow_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wire logic quiet = !sfr_wr && !bit_wr;
    t0_set_a: assert property (timer_zero_ovf && timer_zero_run |=> timer_zero_overflow_flag)
        else $error("t0 set");
    t1_set_a: assert property (
        timer_one_ovf && timer_one_run && !timer_zero_split_mode |=> timer_one_overflow_flag)
        else $error("t1 set");
    split_set_a: assert property (
        timer_zero_upper_byte_ovf && timer_one_run && timer_zero_split_mode |=> timer_one_overflow_flag)
        else $error("split set");
    split_block_a: assert property (
        timer_zero_split_mode && !timer_zero_upper_byte_ovf && quiet |=> !$rose(timer_one_overflow_flag))
        else $error("split block");
    t0_vec_a: assert property (vector_timer_zero && !timer_zero_ovf && quiet |=> !timer_zero_overflow_flag)
        else $error("t0 vec");
    t1_vec_a: assert property (
        vector_timer_one && !timer_one_ovf && !timer_zero_upper_byte_ovf && quiet |=> !timer_one_overflow_flag)
        else $error("t1 vec");
    sw_clear1_a: assert property (
        bit_wr && !sfr_wr && bit_addr == 8'h8F && !bit_wdata && !timer_one_ovf && !timer_zero_upper_byte_ovf
        |=> !timer_one_overflow_flag)
        else $error("software clear of timer one flag");
    sw_clear0_a: assert property (
        bit_wr && !sfr_wr && bit_addr == 8'h8D && !bit_wdata && !timer_zero_ovf |=> !timer_zero_overflow_flag)
        else $error("software clear of timer zero flag");
    run0_gate_a: assert property (!timer_zero_run && quiet |=> !$rose(timer_zero_overflow_flag))
        else $error("run0 gate");
    run1_gate_a: assert property (!timer_one_run && quiet |=> !$rose(timer_one_overflow_flag))
        else $error("run1 gate");
endmodule
bind tovf_timer_flags tovf_timer_flags_assertions chk (.clock, .rst_n, .sfr_wr, .bit_wr, .bit_addr, .bit_wdata,
    .timer_zero_ovf, .timer_one_ovf,
    .timer_zero_upper_byte_ovf, .timer_zero_split_mode, .vector_timer_zero, .vector_timer_one, .timer_zero_run,
    .timer_one_run, .timer_zero_overflow_flag, .timer_one_overflow_flag);

// *** dv/tovf_cpu_model.sv ***
// Interrupt vectoring model: acknowledges a pending flag after dly cycles
module tovf_cpu_model (
    input wire logic clock,
    input wire logic flag,
    input wire logic [1:0] dly,
    output logic vec
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt = 2'h0;
    initial vec = 1'b0;
    always @(posedge clock) begin
        vec <= 1'b0;
        if (!flag || vec) cnt <= 2'h0;
        else if (cnt == dly) vec <= 1'b1;
        else cnt <= cnt + 2'h1;
    end
endmodule

// *** dv/tovf_timer_flags_bench.sv ***
// Random bench with reference model for the timer overflow flag block
module tovf_timer_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 0, go = 0;
    logic timer_zero_ovf = 0, timer_one_ovf = 0, timer_zero_upper_byte_ovf = 0, timer_zero_split_mode = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, sfr_rdata;
    logic [1:0] d0 = 2'h0, d1 = 2'h0;
    logic [31:0] x;
    logic vector_timer_zero, vector_timer_one, timer_zero_run, timer_one_run;
    logic timer_zero_overflow_flag, timer_one_overflow_flag;
    logic [7:0] outs;
    integer seed = 29, error_cnt = 0, comparisons = 0, r = 0, n, rx = 0, i;
    tovf_timer_flags dut (.clock, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_addr, .bit_wr,
        .bit_wdata, .timer_zero_ovf, .timer_one_ovf, .timer_zero_upper_byte_ovf, .timer_zero_split_mode,
        .vector_timer_zero, .vector_timer_one, .timer_zero_run, .timer_one_run, .timer_zero_overflow_flag,
        .timer_one_overflow_flag);
    tovf_cpu_model cpu0 (.clock(clock), .flag(timer_zero_overflow_flag), .dly(d0), .vec(vector_timer_zero));
    tovf_cpu_model cpu1 (.clock(clock), .flag(timer_one_overflow_flag), .dly(d1), .vec(vector_timer_one));
    assign outs = {timer_one_overflow_flag, timer_one_run, timer_zero_overflow_flag, timer_zero_run, 4'h0};
    initial forever #12.5 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // Set beats software write beats vector clear
    always @(posedge clock) if (go) begin
        n = r;
        if (vector_timer_zero) n[5] = 0;
        if (vector_timer_one) n[7] = 0;
        if (sfr_wr && sfr_addr == 8'h88) n = sfr_wdata & 8'hF0;
        else if (bit_wr && bit_addr[7:3] == 5'h11) n[bit_addr[2:0]] = bit_wdata;
        // Low nibble is not stored and reads zero
        n[3:0] = 4'h0;
        if (timer_zero_ovf && r[4]) n[5] = 1;
        if ((timer_zero_split_mode ? timer_zero_upper_byte_ovf : timer_one_ovf) && r[6]) n[7] = 1;
        rx <= (sfr_rd && sfr_addr == 8'h88) ? r : 0;
        r <= n;
    end
    always @(negedge clock) if (go) begin
        chk(outs, r[7:0]);
        chk(sfr_rdata, rx[7:0]);
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1;
        repeat (3) @(posedge clock);
        go <= 1;
        for (i = 0; i < 3000; i++) begin
            @(posedge clock);
            x = $random(seed);
            sfr_wr <= x[3:0] == 0;
            sfr_rd <= x[4];
            bit_wr <= x[7:5] == 0;
            // Unmapped byte and bit addresses mixed in
            sfr_addr <= x[8] ? 8'h88 : 8'h8C;
            bit_addr <= {4'h8, x[9], x[12:10]};
            sfr_wdata <= x[20:13];
            bit_wdata <= x[21];
            timer_zero_ovf <= x[22];
            timer_one_ovf <= x[23];
            timer_zero_upper_byte_ovf <= x[24];
            d0 <= x[26:25];
            d1 <= x[28:27];
            timer_zero_split_mode <= x[31:30] == 0;
        end
        final_report;
    end
    initial begin
        #(3500 * 25);
        error_cnt++;
        final_report;
    end
endmodule
